// ==== hw/imuodr_pkg.sv ====
package imuodr_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets, 16-bit words
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_ACCEL_Y_LOW       = 7'h14;
  localparam logic [6:0] ADDR_ACCEL_Y_HIGH      = 7'h16;
  localparam logic [6:0] ADDR_ACCEL_Z_LOW       = 7'h18;
  localparam logic [6:0] ADDR_ACCEL_Z_HIGH      = 7'h1a;
  localparam logic [6:0] ADDR_DIE_TEMPERATURE   = 7'h1c;
  localparam logic [6:0] ADDR_SYNC_ELAPSED_TIME = 7'h1e;
  localparam logic [6:0] ADDR_UPDATE_COUNTER    = 7'h22;
  localparam logic [6:0] ADDR_DANGLE_X_LOW      = 7'h24;
  localparam logic [6:0] ADDR_DANGLE_X_HIGH     = 7'h26;

  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int         SYNC_MODE_LSB    = 2;
  localparam int         SYNC_MODE_MSB    = 3;
  localparam logic [1:0] SYNC_MODE_SCALED = 2'h2;
  localparam logic [15:0] COUNTER_RESET   = 16'h0000;
  localparam logic [15:0] STAMP_MAX       = 16'hffff;
  localparam logic [15:0] UNMAPPED_DATA   = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam real CLK_MHZ          = 20.0;
  localparam real STAMP_STEP_US    = 49.02;
  localparam int  STAMP_STEP_CYC   = $rtoi(STAMP_STEP_US * CLK_MHZ);
  localparam int  STAMP_PRESC_W    = 10;
  localparam logic [STAMP_PRESC_W-1:0] STAMP_PRESC_LAST =
    STAMP_PRESC_W'(STAMP_STEP_CYC - 1);
  localparam int  NOMINAL_SPS      = 2000;

  // ----------------------------------------------------------------
  // Delta angle full-scale range per model variant, degrees
  // ----------------------------------------------------------------
  localparam int  DANGLE_RANGE_V1  = 360;
  localparam int  DANGLE_RANGE_V2  = 720;
  localparam int  DANGLE_RANGE_V3  = 2160;
  localparam int  DANGLE_W         = 32;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] accel_y;
    logic [31:0] accel_z;
    logic [15:0] temp;
    logic [31:0] rate_x;
  } imuodr_sample_t;

  typedef struct packed {
    logic       rd_en;
    logic [6:0] addr;
  } imuodr_rd_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } imuodr_rd_rsp_t;

endpackage : imuodr_pkg

// ==== hw/imuodr_stamp_timer.sv ====
`timescale 1ns/1ps
module imuodr_stamp_timer (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        enable,
  input  wire logic        sync_edge,
  // Elapsed time in steps
  output logic [15:0]      elapsed
);

  logic [imuodr_pkg::STAMP_PRESC_W-1:0] presc_reg;
  logic [15:0]                          elapsed_reg;

  assign elapsed = elapsed_reg;

  // Step prescaler and elapsed count, restarted by each sync edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg   <= '0;
      elapsed_reg <= 16'h0000;
    end else if (!enable || sync_edge) begin
      presc_reg   <= '0;
      elapsed_reg <= 16'h0000;
    end else if (presc_reg == imuodr_pkg::STAMP_PRESC_LAST) begin
      presc_reg <= '0;
      if (elapsed_reg != imuodr_pkg::STAMP_MAX) begin
        elapsed_reg <= elapsed_reg + 16'h0001;
      end
    end else begin
      presc_reg <= presc_reg + 1'b1;
    end
  end

  stamp_mode_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !enable |=> elapsed_reg == 16'h0000)
    else $error("elapsed time counted outside scaled sync mode");

  stamp_step_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    enable && !sync_edge && presc_reg == imuodr_pkg::STAMP_PRESC_LAST
      && elapsed_reg != imuodr_pkg::STAMP_MAX
    |=> elapsed_reg == $past(elapsed_reg) + 16'h0001)
    else $error("elapsed time missed its step");

endmodule : imuodr_stamp_timer

// ==== hw/imuodr_top.sv ====
`timescale 1ns/1ps
// What this block does
// - Low accel word holds extra resolution bits
// - High accel word two's complement, 12.25 mm/s2
// - Temperature two's complement, 0.1 degree steps
// - Elapsed time since sync, 49.02 us steps
// - Elapsed time applies in scaled sync mode
// - Elapsed time taken at update's last sample
// - Update counter zero after reset or command
// - Update counter increments on every update
// - Update counter wraps from max to zero
// - Delta angle is trapezoidal rate integration
// - Samples per result equal decimation plus one
// - Internal sample rate nominally 2000 per second
// - Delta angle split into two 16-bit words
// - Full-scale delta angle depends on variant
// - Delta angle high word LSB is range/2^15
// - Delta angle low register holds lower bits
// - Output registers read-only, no reset default except the update counter
module imuodr_top (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // Sample stream from the sensor front end
  input  wire logic                       sample_valid,
  input  wire imuodr_pkg::imuodr_sample_t sample,
  // Control
  input  wire logic [15:0]                misc_control_reg,
  input  wire logic [15:0]                dec_rate,
  input  wire logic                       sync_pin,
  input  wire logic                       reset_cmd,
  // Register read port
  input  wire imuodr_pkg::imuodr_rd_req_t rd_req,
  output imuodr_pkg::imuodr_rd_rsp_t      rd_rsp,
  // Data ready
  output logic                            sample_ready_pin
);

  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  logic [15:0]                 dec_cnt_reg;
  logic                        sync_prev_reg;
  logic                        sync_edge;
  logic                        scaled_mode;
  logic                        update_now;
  logic [15:0]                 stamp_now;
  logic [31:0]                 dangle_x;
  logic [31:0]                 accel_y_reg;
  logic [31:0]                 accel_z_reg;
  logic [15:0]                 temp_reg;
  logic [15:0]                 stamp_reg;
  logic [15:0]                 counter_reg;
  logic                        ready_reg;
  imuodr_pkg::imuodr_rd_rsp_t  rd_rsp_reg;
  imuodr_pkg::imuodr_rd_rsp_t  rd_rsp_next;

  assign rd_rsp           = rd_rsp_reg;
  assign sample_ready_pin = ready_reg;

  // ----------------------------------------------------------------
  // Sync mode and sync edge
  // ----------------------------------------------------------------

  // Scaled sync mode select from the control field
  assign scaled_mode = misc_control_reg[imuodr_pkg::SYNC_MODE_MSB:imuodr_pkg::SYNC_MODE_LSB]
                       == imuodr_pkg::SYNC_MODE_SCALED;

  // Previous level of the sync pin for edge detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_prev_reg <= 1'b0;
    end else begin
      sync_prev_reg <= sync_pin;
    end
  end

  // Rising edge of the external timing pin
  assign sync_edge = sync_pin && !sync_prev_reg;

  // Elapsed time since the latest sync edge
  imuodr_stamp_timer u_stamp (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .enable    (scaled_mode),
    .sync_edge (sync_edge),
    .elapsed   (stamp_now)
  );

  // ----------------------------------------------------------------
  // Decimation: one update per dec_rate + 1 samples
  // ----------------------------------------------------------------

  // Update happens on the last sample of each group
  assign update_now = sample_valid && (dec_cnt_reg == dec_rate);

  // Samples seen in the current group
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_cnt_reg <= 16'h0000;
    end else if (reset_cmd) begin
      dec_cnt_reg <= 16'h0000;
    end else if (sample_valid) begin
      dec_cnt_reg <= update_now ? 16'h0000 : dec_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Delta angle, X axis
  // ----------------------------------------------------------------

  // Trapezoidal sum over the group; samples arrive at the internal
  // rate, so the 1/(2*fs) weight is a fixed scale in the rate word
  imuodr_trap_integ #(
    .W (imuodr_pkg::DANGLE_W)
  ) u_dangle_x (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .clear    (reset_cmd),
    .in_valid (sample_valid),
    .in_last  (update_now),
    .in_data  (sample.rate_x),
    .sum_out  (dangle_x)
  );

  // ----------------------------------------------------------------
  // Output data registers, loaded together at each update
  // ----------------------------------------------------------------

  // Data words carry no reset value
  always_ff @(posedge sys_clk) begin
    if (update_now && !reset_cmd) begin
      accel_y_reg <= sample.accel_y;
      accel_z_reg <= sample.accel_z;
      temp_reg    <= sample.temp;
      stamp_reg   <= stamp_now;
    end
  end

  // Update counter, restarted by reset or a reset command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_reg <= imuodr_pkg::COUNTER_RESET;
    end else if (reset_cmd) begin
      counter_reg <= imuodr_pkg::COUNTER_RESET;
    end else if (update_now) begin
      counter_reg <= counter_reg + 16'h0001;
    end
  end

  // Data ready pulse marks each fresh set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= update_now && !reset_cmd;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------

  // Read-only decode; unmapped addresses read zero
  always_comb begin
    rd_rsp_next.valid = rd_req.rd_en;
    rd_rsp_next.data  = imuodr_pkg::UNMAPPED_DATA;
    unique case (rd_req.addr)
      imuodr_pkg::ADDR_ACCEL_Y_LOW: begin
        rd_rsp_next.data = accel_y_reg[15:0];
      end
      imuodr_pkg::ADDR_ACCEL_Y_HIGH: begin
        rd_rsp_next.data = accel_y_reg[31:16];
      end
      imuodr_pkg::ADDR_ACCEL_Z_LOW: begin
        rd_rsp_next.data = accel_z_reg[15:0];
      end
      imuodr_pkg::ADDR_ACCEL_Z_HIGH: begin
        rd_rsp_next.data = accel_z_reg[31:16];
      end
      imuodr_pkg::ADDR_DIE_TEMPERATURE: begin
        rd_rsp_next.data = temp_reg;
      end
      imuodr_pkg::ADDR_SYNC_ELAPSED_TIME: begin
        rd_rsp_next.data = stamp_reg;
      end
      imuodr_pkg::ADDR_UPDATE_COUNTER: begin
        rd_rsp_next.data = counter_reg;
      end
      imuodr_pkg::ADDR_DANGLE_X_LOW: begin
        rd_rsp_next.data = dangle_x[15:0];
      end
      imuodr_pkg::ADDR_DANGLE_X_HIGH: begin
        rd_rsp_next.data = dangle_x[31:16];
      end
      default: begin
        rd_rsp_next.data = imuodr_pkg::UNMAPPED_DATA;
      end
    endcase
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_rsp_reg <= '0;
    end else begin
      rd_rsp_reg <= rd_rsp_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  // Update counter
  cnt_restart_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    reset_cmd |=> counter_reg == 16'h0000)
    else $error("update counter not zero after reset command");

  cnt_incr_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    update_now && !reset_cmd |=> counter_reg == $past(counter_reg) + 16'h0001)
    else $error("update counter did not step by one");

  cnt_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !update_now && !reset_cmd |=> $stable(counter_reg))
    else $error("update counter moved without an update");

  cnt_wrap_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    update_now && !reset_cmd && counter_reg == 16'hffff |=> counter_reg == 16'h0000)
    else $error("update counter did not wrap to zero");

  // Decimation and reset command
  dec_group_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sample_valid && !reset_cmd && dec_cnt_reg != dec_rate
    |=> !ready_reg && dec_cnt_reg == $past(dec_cnt_reg) + 16'h0001)
    else $error("update issued before the group was complete");

  cmd_group_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    reset_cmd |=> dec_cnt_reg == 16'h0000)
    else $error("decimation count not cleared by reset command");

  cmd_quiet_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    reset_cmd |=> !ready_reg)
    else $error("update taken during a reset command");

  dec_close_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    update_now && !reset_cmd |=> dec_cnt_reg == 16'h0000)
    else $error("decimation count not restarted after an update");

  // Output set and elapsed time
  set_together_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    update_now && !reset_cmd
    |=> ready_reg && accel_y_reg == $past(sample.accel_y)
        && accel_z_reg == $past(sample.accel_z)
        && temp_reg == $past(sample.temp) && stamp_reg == $past(stamp_now))
    else $error("output set not loaded together");

  sync_restart_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sync_edge && scaled_mode ##1 update_now && !reset_cmd
    |=> stamp_reg == 16'h0000)
    else $error("elapsed time not restarted by sync edge");

  sync_zero_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sync_edge && scaled_mode |=> stamp_now == 16'h0000)
    else $error("elapsed timer not zeroed by sync edge");

  stamp_off_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    update_now && !reset_cmd && !scaled_mode && $past(!scaled_mode)
    |=> stamp_reg == 16'h0000)
    else $error("elapsed time stored outside scaled sync mode");

  // Read port
  read_count_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rd_req.rd_en && rd_req.addr == imuodr_pkg::ADDR_UPDATE_COUNTER
    |=> rd_rsp_reg.valid && rd_rsp_reg.data == $past(counter_reg))
    else $error("counter read answered wrongly");

  read_idle_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !rd_req.rd_en |=> !rd_rsp_reg.valid)
    else $error("read answer without a request");

  read_odd_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rd_req.rd_en && rd_req.addr[0]
    |=> rd_rsp_reg.valid && rd_rsp_reg.data == imuodr_pkg::UNMAPPED_DATA)
    else $error("odd byte address did not read as unmapped");

endmodule : imuodr_top

// ==== hw/imuodr_trap_integ.sv ====
`timescale 1ns/1ps
module imuodr_trap_integ #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         clear,
  // Samples
  input  wire logic         in_valid,
  input  wire logic         in_last,
  input  wire logic [W-1:0] in_data,
  // Result
  output logic [W-1:0]      sum_out
);

  localparam int AW = W + 18;

  logic signed [AW-1:0] acc_reg;
  logic signed [W-1:0]  prev_reg;
  logic signed [W-1:0]  sum_reg;
  logic signed [AW-1:0] term;
  logic signed [AW-1:0] total;
  logic signed [AW-1:0] pos_lim;
  logic signed [AW-1:0] neg_lim;

  assign sum_out = sum_reg;
  // Sample plus predecessor, widened so no sum can overflow
  assign term  = AW'(signed'(in_data)) + AW'(prev_reg);
  assign total = acc_reg + term;
  assign pos_lim = AW'({1'b0, {(W-1){1'b1}}});
  assign neg_lim = -pos_lim - AW'(1);

  // Running sum; the predecessor carries across result boundaries
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg  <= '0;
      prev_reg <= '0;
    end else if (clear) begin
      acc_reg  <= '0;
      prev_reg <= '0;
    end else if (in_valid) begin
      prev_reg <= in_data;
      acc_reg  <= in_last ? '0 : total;
    end
  end

  // Result word, clamped to the signed full-scale range
  always_ff @(posedge sys_clk) begin
    if (in_valid && in_last && !clear) begin
      if (total > pos_lim) begin
        sum_reg <= pos_lim[W-1:0];
      end else if (total < neg_lim) begin
        sum_reg <= neg_lim[W-1:0];
      end else begin
        sum_reg <= total[W-1:0];
      end
    end
  end

  integ_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    in_valid && in_last && !clear |=> acc_reg == '0 && prev_reg == $past(in_data))
    else $error("integration did not restart after a result");

endmodule : imuodr_trap_integ

// ==== test/imuodr_host_model.sv ====
`timescale 1ns/1ps
module imuodr_host_model (
  // Clock
  input  wire logic                       sys_clk,
  // Register read port
  output imuodr_pkg::imuodr_rd_req_t      rd_req,
  input  wire imuodr_pkg::imuodr_rd_rsp_t rd_rsp,
  // Data ready
  input  wire logic                       sample_ready_pin
);
  // ------------------------------------------------------------
  // Host side of the register read port
  // ------------------------------------------------------------
  int unsigned ready_seen = 0;

  // Ready pulses are counted so the test can compare them with the updates it expects
  always @(posedge sys_clk) begin
    if (sample_ready_pin === 1'b1) begin
      ready_seen <= ready_seen + 1;
    end
  end

  initial rd_req = '0;

  // One read: request stands for one edge, the answer is taken one edge later
  task automatic read_word(input logic [6:0] addr, output logic vld, output logic [15:0] data);
    @(negedge sys_clk);
    rd_req = {1'b1, addr};
    @(negedge sys_clk);
    rd_req = {1'b0, ~addr}; // Released address does not keep its last value
    vld = rd_rsp.valid;
    data = rd_rsp.data;
  endtask : read_word
endmodule : imuodr_host_model

// ==== test/test_imuodr_top.sv ====
`timescale 1ns/1ps
module test_imuodr_top;
  // ------------------------------------------------------------
  // Signals and expectation state
  // ------------------------------------------------------------
  logic                       sys_clk, rst_n, sample_valid, sync_pin, reset_cmd;
  logic                       sample_ready_pin;
  logic [15:0]                misc_control_reg, dec_rate, exp_cnt;
  logic [31:0]                prev_rate, last_rate, last_sum;
  longint                     acc;
  int                         ready_exp = 0;
  imuodr_pkg::imuodr_sample_t sample;
  imuodr_pkg::imuodr_rd_req_t rd_req;
  imuodr_pkg::imuodr_rd_rsp_t rd_rsp;
  int                         failures = 0;
  int                         checks_done = 0;

  imuodr_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .sample_valid(sample_valid),
    .sample(sample), .misc_control_reg(misc_control_reg), .dec_rate(dec_rate),
    .sync_pin(sync_pin), .reset_cmd(reset_cmd), .rd_req(rd_req), .rd_rsp(rd_rsp),
    .sample_ready_pin(sample_ready_pin));

  imuodr_host_model host (.sys_clk(sys_clk), .rd_req(rd_req), .rd_rsp(rd_rsp),
    .sample_ready_pin(sample_ready_pin));

  // Clock, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Compare, access and closing tasks
  // ------------------------------------------------------------
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic check_count(input int got, input int exp, input string what);
    checks_done++;
    if (got != exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask : check_count

  task automatic rd(input logic [6:0] addr, input logic [15:0] exp);
    logic        v;
    logic [15:0] d;
    host.read_word(addr, v, d);
    check_bit(v, 1'b1, "read answer");
    check_word(d, exp, "read data");
  endtask : rd

  // One sample; the ready pin must pulse only when it closes a group
  task automatic send(input logic [31:0] rate, input logic upd);
    @(negedge sys_clk);
    sample_valid = 1'b1;
    sample.accel_y = rate ^ 32'h5a5a0000;
    sample.accel_z = rate + 32'h00010003;
    sample.temp = rate[15:0] ^ 16'h0fa0;
    sample.rate_x = rate;
    acc = acc + longint'(signed'(rate)) + longint'(signed'(prev_rate));
    prev_rate = rate;
    @(negedge sys_clk);
    sample_valid = 1'b0;
    sample = ~sample;
    check_bit(sample_ready_pin, upd, "ready pulse");
    @(negedge sys_clk);
    check_bit(sample_ready_pin, 1'b0, "ready one cycle");
    if (upd) begin
      last_rate = rate;
      if (acc > 64'sd2147483647) begin
        last_sum = 32'h7fffffff;
      end else if (acc < -64'sd2147483648) begin
        last_sum = 32'h80000000;
      end else begin
        last_sum = acc[31:0];
      end
      acc = '0;
      ready_exp++;
      exp_cnt = exp_cnt + 16'h0001;
    end
  endtask : send

  // Every output word of the latest update except the elapsed time
  task automatic check_regs();
    logic [31:0] ay;
    logic [31:0] az;
    ay = last_rate ^ 32'h5a5a0000;
    az = last_rate + 32'h00010003;
    rd(imuodr_pkg::ADDR_ACCEL_Y_LOW, ay[15:0]);
    rd(imuodr_pkg::ADDR_ACCEL_Y_HIGH, ay[31:16]);
    rd(imuodr_pkg::ADDR_ACCEL_Z_LOW, az[15:0]);
    rd(imuodr_pkg::ADDR_ACCEL_Z_HIGH, az[31:16]);
    rd(imuodr_pkg::ADDR_DIE_TEMPERATURE, last_rate[15:0] ^ 16'h0fa0);
    rd(imuodr_pkg::ADDR_UPDATE_COUNTER, exp_cnt);
    rd(imuodr_pkg::ADDR_DANGLE_X_LOW, last_sum[15:0]);
    rd(imuodr_pkg::ADDR_DANGLE_X_HIGH, last_sum[31:16]);
  endtask : check_regs

  task automatic close_out();
    $display("Checks done %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // Watchdog sized well above the longest sequence
  initial begin
    repeat (90000) @(posedge sys_clk);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    close_out();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    sample_valid = 1'b0;
    sample = '0;
    misc_control_reg = 16'h0000;
    dec_rate = 16'h0000;
    sync_pin = 1'b0;
    reset_cmd = 1'b0;
    exp_cnt = 16'h0000;
    acc = '0;
    prev_rate = '0;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    rd(imuodr_pkg::ADDR_UPDATE_COUNTER, 16'h0000);
    rd(7'h20, imuodr_pkg::UNMAPPED_DATA);
    rd(7'h15, imuodr_pkg::UNMAPPED_DATA);
    $display("Test reset state done");
    // Single-sample updates, negative then positive
    send(32'hfffe8001, 1'b1);
    check_regs();
    send(32'h00012345, 1'b1);
    check_regs();
    $display("Test single updates done");
    // Three samples per update
    dec_rate = 16'h0002;
    send(32'h00000100, 1'b0);
    send(32'h00000200, 1'b0);
    send(32'h00000300, 1'b1);
    check_regs();
    $display("Test decimation done");
    // Reset command clears counter and predecessor
    @(negedge sys_clk);
    reset_cmd = 1'b1;
    @(negedge sys_clk);
    reset_cmd = 1'b0;
    exp_cnt = 16'h0000;
    prev_rate = '0;
    rd(imuodr_pkg::ADDR_UPDATE_COUNTER, 16'h0000);
    dec_rate = 16'h0000;
    send(32'h00000007, 1'b1);
    check_regs();
    $display("Test reset command done");
    // Elapsed time in scaled sync mode, taken at the last sample of a pair
    dec_rate = 16'h0001;
    misc_control_reg = {12'h000, imuodr_pkg::SYNC_MODE_SCALED, 2'h0};
    sync_pin = 1'b1;
    repeat (imuodr_pkg::STAMP_STEP_CYC * 3 / 2) @(negedge sys_clk);
    send(32'h00000011, 1'b0);
    repeat (imuodr_pkg::STAMP_STEP_CYC * 2) @(negedge sys_clk);
    send(32'h00000012, 1'b1);
    rd(imuodr_pkg::ADDR_SYNC_ELAPSED_TIME, 16'h0003);
    misc_control_reg = 16'h0000;
    sync_pin = 1'b0;
    send(32'h00000013, 1'b0);
    send(32'h00000014, 1'b1);
    rd(imuodr_pkg::ADDR_SYNC_ELAPSED_TIME, 16'h0000);
    // A sync edge just before an update restarts the stored time
    dec_rate = 16'h0000;
    misc_control_reg = {12'h000, imuodr_pkg::SYNC_MODE_SCALED, 2'h0};
    repeat (imuodr_pkg::STAMP_STEP_CYC * 2) @(negedge sys_clk);
    sync_pin = 1'b1;
    send(32'h00000015, 1'b1);
    rd(imuodr_pkg::ADDR_SYNC_ELAPSED_TIME, 16'h0000);
    misc_control_reg = 16'h0000;
    sync_pin = 1'b0;
    $display("Test elapsed time done");
    // Counter runs up to its maximum, then wraps
    dec_rate = 16'h0000;
    @(negedge sys_clk);
    sample_valid = 1'b1;
    sample.rate_x = 32'h00000010;
    repeat (int'(16'hffff - exp_cnt)) @(negedge sys_clk);
    sample_valid = 1'b0;
    ready_exp = ready_exp + int'(16'hffff - exp_cnt);
    exp_cnt = 16'hffff;
    prev_rate = 32'h00000010;
    acc = '0;
    repeat (2) @(negedge sys_clk);
    rd(imuodr_pkg::ADDR_UPDATE_COUNTER, 16'hffff);
    send(32'h00000020, 1'b1);
    check_regs();
    send(32'h00000021, 1'b1);
    rd(imuodr_pkg::ADDR_UPDATE_COUNTER, 16'h0001);
    $display("Test counter wrap done");
    // Sums beyond the signed 32-bit range clamp to full scale
    send(32'h7fffffff, 1'b1);
    check_regs();
    send(32'h80000000, 1'b1);
    send(32'h80000000, 1'b1);
    check_regs();
    check_count(host.ready_seen, ready_exp, "ready pulses");
    $display("Test saturation done");
    close_out();
  end
endmodule : test_imuodr_top
